// file: regfile_model.sv
// register file model: 128 bytes, combinational read port
// assumes writes arrive as one-cycle strobes on mclk
`timescale 1ns/100ps
// ==========================================================================
// data register file
// ==========================================================================
module regfile_model (
    input  wire logic       mclk,
    input  wire logic [6:0] rd_addr,
    output logic [7:0]      rd_data,
    input  wire logic       wr_en,
    input  wire logic [6:0] wr_addr,
    input  wire logic [7:0] wr_data
);
    logic [7:0] mem [128];
    // each byte seeded with three times its address
    initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 3);
    assign rd_data = mem[rd_addr];
    // store on the write strobe
    always @(posedge mclk) if (wr_en) mem[wr_addr] <= wr_data;
endmodule : regfile_model

// file: subtract_arith.sv
// ==========================================================================
// subtract arithmetic: shared package and the combinational subtractor
// ==========================================================================
// holds opcode patterns, flag layout and the 8-bit subtract-with-flags core.
// assumes a single core clock; the core module is purely combinational.
`timescale 1ns/100ps

package subtract_pkg;
    localparam int DATA_W  = 8;
    localparam int INSTR_W = 14;
    localparam int ADDR_W  = 7;
    // literal form: 11 110x kkkk kkkk, top five bits fixed
    localparam logic [4:0] LIT_OPC  = 5'h1E;
    localparam int         LIT_MSB  = 13;
    localparam int         LIT_LSB  = 9;
    // register form: 00 0010 dfff ffff, top six bits fixed
    localparam logic [5:0] FILE_OPC = 6'h02;
    localparam int         FILE_LSB = 8;
    localparam int         DEST_BIT = 7;
    // reset values
    localparam logic [7:0] W_RESET  = 8'h00;

    typedef struct packed {
        logic carry;
        logic digit_carry_flag;
        logic zero;
    } flags_t;

    localparam flags_t FLAGS_RESET = '{carry: 1'b0, digit_carry_flag: 1'b0, zero: 1'b0};
endpackage : subtract_pkg

// ==========================================================================
// subtractor: minuend minus subtrahend, carry as inverted borrow
// ==========================================================================
module subtract_core (
    input  wire logic [7:0]          minuend,
    input  wire logic [7:0]          subtrahend,
    output logic [7:0]               diff,
    output subtract_pkg::flags_t     flags
);
    logic [8:0] full_sum;
    logic [4:0] low_sum;

    // two's complement add of the inverted subtrahend plus one
    assign full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
    assign low_sum  = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
    assign diff                   = full_sum[7:0];
    assign flags.carry            = full_sum[8];
    assign flags.digit_carry_flag = low_sum[4];
    assign flags.zero             = (full_sum[7:0] == 8'h00);
endmodule : subtract_core

// file: subtract_instruction_datapath.sv
// ==========================================================================
// subtract instruction datapath slice
// ==========================================================================
// executes the literal and register subtract instructions in one cycle.
// assumes the register file answers reg_rd_addr combinationally on mclk.
// opcodes other than the two subtracts pass through: no flag change, no pulse.
// a side load of w loses to a subtract that writes w in the same cycle.
// write-back address and data move every cycle; only the strobe qualifies them.
// flags keep their value between subtracts, so a reader may sample them late.
//
// Behaviour
// [RULE1] literal subtract computes immediate minus working register into the working register.
// [RULE2] register subtract computes the addressed register minus the working register.
// [RULE3] with destination bit zero the difference goes to the working register only.
// [RULE4] with destination bit one the difference goes back to the addressed register only.
// [RULE5] carry is set when the minuend exceeds the subtrahend, an inverted borrow.
// [RULE6] carry is set when minuend and subtrahend are equal and the difference is zero.
// [RULE7] carry is cleared and the wrapped difference stored when the subtrahend is larger.
// [RULE8] zero flag marks a zero difference; digit carry is the inverted low-nibble borrow.
`timescale 1ns/100ps

module subtract_instruction_datapath (
    input  wire logic [13:0]          instr,
    input  wire logic                 instr_valid,
    input  wire logic [7:0]           reg_rd_data,
    input  wire logic                 w_load,
    input  wire logic [7:0]           w_load_data,
    input  wire logic                 mclk,
    input  wire logic                 srst,
    output logic [6:0]                reg_rd_addr,
    output logic [7:0]                w_r,
    output subtract_pkg::flags_t      flags_r,
    output logic                      file_wr_en_r,
    output logic [6:0]                file_wr_addr_r,
    output logic [7:0]                file_wr_data_r,
    output logic                      done_r
);
    // ======================================================================
    // decode
    // ======================================================================
    logic       lit_hit;
    logic       file_hit;
    logic       dest_file;
    logic [7:0] imm;
    logic [7:0] minuend;
    logic [7:0] diff;
    subtract_pkg::flags_t flags_nxt;
    logic [7:0] w_nxt;
    logic       file_wr_en_nxt;
    logic       exec;
    logic       w_takes_diff;

    // opcode matches gated by the valid strobe
    assign lit_hit   = instr_valid &&
                       (instr[subtract_pkg::LIT_MSB:subtract_pkg::LIT_LSB]
                        == subtract_pkg::LIT_OPC);
    assign file_hit  = instr_valid &&
                       (instr[subtract_pkg::LIT_MSB:subtract_pkg::FILE_LSB]
                        == subtract_pkg::FILE_OPC);
    assign dest_file = instr[subtract_pkg::DEST_BIT];
    assign imm       = instr[7:0];
    assign reg_rd_addr = instr[6:0];

    // any taken subtract, and whether its difference lands in w
    assign exec         = lit_hit || file_hit;
    assign w_takes_diff = lit_hit || (file_hit && !dest_file);

    // minuend selection, working register is always the subtrahend
    assign minuend = lit_hit ? imm : reg_rd_data;   // see [RULE1] see [RULE2]

    // ======================================================================
    // arithmetic
    // ======================================================================
    subtract_core u_core (
        .minuend    (minuend),
        .subtrahend (w_r),
        .diff       (diff),
        .flags      (flags_nxt)                      // see [RULE5] see [RULE8]
    );

    // destination steering
    assign w_nxt = w_takes_diff ? diff :                              // see [RULE3]
                   (w_load ? w_load_data : w_r);
    assign file_wr_en_nxt = file_hit && dest_file;                    // see [RULE4]

    // ======================================================================
    // state
    // ======================================================================
    // working register, loaded by a subtract or by the side port
    always_ff @(posedge mclk) begin
        if (srst) begin
            w_r <= subtract_pkg::W_RESET;
        end else begin
            w_r <= w_nxt;                                             // see [RULE7]
        end
    end

    // flags move only when a subtract is taken
    always_ff @(posedge mclk) begin
        if (srst) begin
            flags_r <= subtract_pkg::FLAGS_RESET;
        end else if (exec) begin
            flags_r <= flags_nxt;                                     // see [RULE6]
        end
    end

    // write-back strobe and completion pulse, one cycle each
    always_ff @(posedge mclk) begin
        if (srst) begin
            file_wr_en_r <= 1'b0;
            done_r       <= 1'b0;
        end else begin
            file_wr_en_r <= file_wr_en_nxt;
            done_r       <= exec;
        end
    end

    // write-back address and data, qualified by the strobe
    always_ff @(posedge mclk) begin
        if (srst) begin
            file_wr_addr_r <= 7'h00;
            file_wr_data_r <= 8'h00;
        end else begin
            file_wr_addr_r <= reg_rd_addr;
            file_wr_data_r <= diff;
        end
    end

    // ======================================================================
    // checks
    // ======================================================================
    logic [7:0] lit_expect;
    logic [7:0] file_expect;
    assign lit_expect  = imm - w_r;
    assign file_expect = reg_rd_data - w_r;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    // literal result into w
    a_lit_result: assert property (lit_hit |=> w_r == $past(lit_expect)) // see [RULE1]
        else $error("literal subtract result wrong");
    // literal never touches the register file
    a_lit_no_wb: assert property (lit_hit |=> !file_wr_en_r) // see [RULE1]
        else $error("literal subtract wrote the register file");
    // bit eight of the literal opcode is a don't-care
    a_lit_dont_care: assert property ( // see [RULE1]
        instr_valid && instr[subtract_pkg::LIT_MSB:subtract_pkg::FILE_LSB]
            == {subtract_pkg::LIT_OPC, 1'b1} |=> done_r)
        else $error("literal subtract with bit eight set not taken");

    // register operand feeds the minuend
    a_file_minuend: assert property (file_hit |-> minuend == reg_rd_data) // see [RULE2]
        else $error("register subtract minuend wrong");
    // register difference on the write-back data
    a_file_diff: assert property (file_hit |=> file_wr_data_r == $past(file_expect)) // see [RULE2]
        else $error("register subtract difference wrong");
    // destination zero: w takes it, no write-back
    a_dest_w: assert property ( // see [RULE3]
        file_hit && !dest_file |=> !file_wr_en_r && w_r == $past(file_expect))
        else $error("destination zero misrouted");
    // destination one: write-back strobe, w kept
    a_dest_file_wb: assert property ( // see [RULE4]
        file_hit && dest_file |=> file_wr_en_r && $stable(w_r)
            && file_wr_addr_r == $past(reg_rd_addr))
        else $error("destination one misrouted");
    // write strobe only from a destination-one subtract
    a_wb_source: assert property (file_wr_en_r |-> $past(file_hit && dest_file)) // see [RULE3]
        else $error("register write without a destination-one subtract");

    // carry above zero
    a_carry_greater: assert property (exec && minuend > w_r |=> flags_r.carry) // see [RULE5]
        else $error("carry not set for positive result");
    // carry at zero
    a_carry_equal: assert property ( // see [RULE6]
        exec && minuend == w_r |=> flags_r.carry && flags_r.zero)
        else $error("carry or zero wrong for equal operands");
    // carry below zero
    a_carry_less: assert property ( // see [RULE7]
        exec && minuend < w_r |=> !flags_r.carry && !flags_r.zero)
        else $error("carry not cleared for negative result");
    // carry is the inverse of the borrow in every case
    a_carry_borrow: assert property ( // see [RULE5]
        exec |=> flags_r.carry == ($past(minuend) >= $past(w_r)))
        else $error("carry differs from inverted borrow");
    // a negative result wraps modulo 256
    a_wrap_diff: assert property ( // see [RULE7]
        exec && minuend < w_r
            |=> file_wr_data_r == 8'(9'h100 + $past(minuend) - $past(w_r)))
        else $error("wrapped difference wrong");

    // digit carry and zero flag
    a_digit_flag: assert property ( // see [RULE8]
        exec |=> flags_r.digit_carry_flag == ($past(minuend[3:0]) >= $past(w_r[3:0])))
        else $error("digit carry wrong");
    a_zero_flag: assert property ( // see [RULE8]
        exec |=> flags_r.zero == ($past(minuend) == $past(w_r)))
        else $error("zero flag wrong");

    // reset clears every output register
    a_reset_clear: assert property (@(posedge mclk) disable iff (1'b0)
        srst |=> w_r == subtract_pkg::W_RESET && flags_r == subtract_pkg::FLAGS_RESET
            && !file_wr_en_r && !done_r)
        else $error("state not cleared by reset");
    // flags and pulse quiet without a subtract
    a_flags_hold: assert property (!exec |=> $stable(flags_r) && !done_r)
        else $error("flags changed without subtract");
    // refused opcodes never write the register file
    a_refuse_quiet: assert property (instr_valid && !exec |=> !file_wr_en_r)
        else $error("unknown opcode wrote the register file");
    // w holds unless something writes it
    a_w_hold: assert property (!exec && !w_load |=> $stable(w_r))
        else $error("working register changed while idle");
    // side load reaches w when no subtract runs
    a_w_load_taken: assert property (w_load && !exec |=> w_r == $past(w_load_data))
        else $error("side load of working register lost");
    // one completion pulse per subtract
    a_done_pulse: assert property (exec |=> done_r) // see [RULE1]
        else $error("completion pulse missing");

    // main scenarios reached
    c_lit_neg: cover property (lit_hit && imm < w_r);
    c_file_to_w: cover property (file_hit && !dest_file);
    c_file_to_reg: cover property (file_hit && dest_file ##1 file_hit);
    c_zero_result: cover property (exec && minuend == w_r);
    c_file_wrap: cover property (file_hit && dest_file && minuend < w_r);
endmodule : subtract_instruction_datapath

// file: tb_top.sv
// self-checking bench for the subtract datapath
// assumes the register file model answers reads in the same cycle
`timescale 1ns/100ps
// ==========================================================================
// bench top
// ==========================================================================
module tb_top;
    logic                 mclk = 1'b0, srst = 1'b1, instr_valid = 1'b0, w_load = 1'b0;
    logic [13:0]          instr = 14'h0000;
    logic [7:0]           w_load_data = 8'h00, rd_data, w_r, wr_data, w_exp;
    logic [6:0]           rd_addr, wr_addr;
    logic                 wr_en, done_r;
    subtract_pkg::flags_t flags_r;
    int                   n_mismatch = 0, checked = 0;
    logic [2:0]           f_exp = 3'h0;
    always #12.5 mclk = ~mclk;
    subtract_instruction_datapath u_dut (.instr(instr), .instr_valid(instr_valid),
        .reg_rd_data(rd_data), .w_load(w_load), .w_load_data(w_load_data), .mclk(mclk),
        .srst(srst), .reg_rd_addr(rd_addr), .w_r(w_r), .flags_r(flags_r),
        .file_wr_en_r(wr_en), .file_wr_addr_r(wr_addr), .file_wr_data_r(wr_data),
        .done_r(done_r));
    regfile_model u_regs (.mclk(mclk), .rd_addr(rd_addr), .rd_data(rd_data),
        .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));
    // compare bytes and single bits
    task automatic chk(input string s, input logic [7:0] e, g);
        checked++;
        if (e !== g) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic chk1(input string s, input logic e, g);
        chk(s, {7'h00, e}, {7'h00, g});
    endtask : chk1
    // working register through the side port
    task automatic load_w(input logic [7:0] v);
        @(posedge mclk);
        w_load <= 1'b1;
        w_load_data <= v;
        @(posedge mclk);
        w_load <= 1'b0;
        w_exp = v;
    endtask : load_w
    // one instruction, outputs settled on return
    task automatic issue(input logic [13:0] op);
        @(posedge mclk);
        instr <= op;
        instr_valid <= 1'b1;
        @(posedge mclk);
        instr_valid <= 1'b0;
        #1;
    endtask : issue
    // subtract with minuend m, judged against w_exp
    task automatic sub(input logic [13:0] op, input logic [7:0] m);
        logic [7:0] d;
        logic       f;
        d = m - w_exp;
        f = (op[13:8] == 6'h02) && op[7];
        f_exp = {m >= w_exp, m[3:0] >= w_exp[3:0], d == 8'h00};
        issue(op);
        chk1("done", 1'b1, done_r);
        chk("rd_addr", {1'b0, op[6:0]}, {1'b0, rd_addr});
        chk1("carry", f_exp[2], flags_r.carry);
        chk1("dc", f_exp[1], flags_r.digit_carry_flag);
        chk1("zero", f_exp[0], flags_r.zero);
        chk1("wr_en", f, wr_en);
        if (f) begin
            chk("wr_data", d, wr_data);
            chk("wr_addr", {1'b0, op[6:0]}, {1'b0, wr_addr});
        end else w_exp = d;
        chk("w", w_exp, w_r);
    endtask : sub
    task automatic t_literal;
        load_w(8'h01);
        sub(14'h3C02, 8'h02);
        load_w(8'h02);
        sub(14'h3C02, 8'h02);
        load_w(8'h03);
        sub(14'h3D02, 8'h02);
        load_w(8'h0F);
        sub(14'h3C10, 8'h10);
    endtask : t_literal
    // address 5 holds 0F; write back, then read the new value
    task automatic t_file;
        load_w(8'h20);
        sub(14'h0285, 8'h0F);
        sub(14'h0205, 8'hEF);
    endtask : t_file
    task automatic t_refuse;
        issue(14'h3A55);
        chk1("done", 1'b0, done_r);
        chk1("wr_en", 1'b0, wr_en);
        chk("flags", {5'h00, f_exp}, {5'h00, flags_r});
        chk("w", w_exp, w_r);
    endtask : t_refuse
    // reset in mid-run, then a subtract driven on the first free edge and taken on the second
    task automatic t_reset;
        @(posedge mclk);
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        #1;
        w_exp = 8'h00;
        chk("w_rst", w_exp, w_r);
        chk("flags_rst", 8'h00, {5'h00, flags_r});
        chk1("done_rst", 1'b0, done_r);
        sub(14'h3C00, 8'h00);
    endtask : t_reset
    task automatic results;
        if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : results
    // reset, scenarios, verdict
    initial begin
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        #1;
        chk("w_rst", 8'h00, w_r);
        t_literal();
        t_file();
        t_refuse();
        t_reset();
        results();
    end
    // watchdog well past the expected run
    initial begin
        #50000;
        n_mismatch++;
        results();
    end
endmodule : tb_top
